//--- logic/ctsc_map.svh
// Offsets, field positions, reset values and counts of the touch scan block
`ifndef CTSC_MAP_SVH
`define CTSC_MAP_SVH
// ==========================================================
// Sizes
`define CTSC_NMOD      2
`define CTSC_NKEY      4
// ==========================================================
// Register byte offsets and address pages
`define CTSC_OFF_CTRL0 12'h000
`define CTSC_OFF_CTRL1 12'h004
`define CTSC_PG_MOD    6'h01
`define CTSC_PG_CAP    7'h08
`define CTSC_PG_RES    7'h10
`define CTSC_SUB_MC1   2'h0
`define CTSC_SUB_MC2   2'h1
`define CTSC_SUB_CAP   2'h2
// ==========================================================
// Field positions
`define CTSC_B_START   0
`define CTSC_B_MODE    1
`define CTSC_B_BUSY    2
`define CTSC_B_OVF     3
`define CTSC_B_SHARED  0
`define CTSC_F_PRESET  15:8
`define CTSC_B_TSS     7
`define CTSC_B_ROEN    5
`define CTSC_B_KOEN    4
`define CTSC_F_KEN     3:0
`define CTSC_B_HIT     32
// ==========================================================
// Reset values, masks and counter limits
`define CTSC_MC1_MASK  8'hbf
`define CTSC_MC2_RST   8'he4
`define CTSC_PRE_RST   8'h00
`define CTSC_SLOT_MAX  8'hff
`define CTSC_UNIT_MAX  5'h1f
`define CTSC_DIV_MAX   2'h3
`define CTSC_LAST_SLOT 2'h3
`define CTSC_RESP_OK   2'h0
`define CTSC_RESP_ERR  2'h2
`endif

//--- logic/ctsc_pkg.sv
// Shared types of the capacitive touch scan controller
`default_nettype none
`include "ctsc_map.svh"
package ctsc_pkg;
  // Sequencer phases
  typedef enum logic [1:0] {ph_idle, ph_load, ph_scan} ctsc_phase_t;
  // Counters of one touch module
  typedef struct packed {
    logic        hold;
    logic [15:0] cf;
    logic [15:0] cnt;
    logic [4:0]  unit;
    logic [7:0]  slot;
  } ctsc_chan_state_t;
  // Whole state of the top level
  typedef struct packed {
    logic start, start_d1, mode, shared, ovf, busy, run, irq;
    logic [7:0]                           preset;
    logic [1:0]                           div;
    logic [1:0]                           slot;
    ctsc_phase_t                          phase;
    logic [`CTSC_NMOD-1:0]                done;
    logic [`CTSC_NMOD-1:0][7:0]           mc1;
    logic [`CTSC_NMOD-1:0][7:0]           mc2;
    logic [`CTSC_NMOD-1:0][9:0]           refcap;
    logic [`CTSC_NMOD*`CTSC_NKEY-1:0][9:0]  capmem;
    logic [`CTSC_NMOD*`CTSC_NKEY-1:0][15:0] resmem;
    logic aw_v, w_v, bvalid, rvalid;
    logic [1:0]                           bresp;
    logic [1:0]                           rresp;
    logic [11:0]                          awaddr;
    logic [31:0]                          wdata;
    logic [3:0]                           wstrb;
    logic [31:0]                          rdata;
  } ctsc_top_state_t;
endpackage
`default_nettype wire

//--- logic/ctsc_chan.sv
// Counter set of one touch module: frequency, period, unit and slot counters
`timescale 1ns/100ps
`default_nettype none
`include "ctsc_map.svh"

module ctsc_chan
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Control from the sequencer
  input  wire logic        run,
  input  wire logic        clr_all,
  input  wire logic        slot_clr,
  input  wire logic        cf_clr,
  input  wire logic        slot_clk_sel,
  input  wire logic        div_tick,
  input  wire logic [7:0]  preset,
  input  wire logic [1:0]  key_sel,
  // Oscillator ticks
  input  wire logic        ref_tick,
  input  wire logic [3:0]  key_tick,
  // Results
  output logic      [15:0] cf_count,
  output logic             slot_ovf
);

  // ==========================================================
  // State and slot clock
  ctsc_pkg::ctsc_chan_state_t q;     // Registered counters
  ctsc_pkg::ctsc_chan_state_t n;     // Next counters
  logic                       tick;  // Slot clock enable
  logic                       live;  // Counting allowed

  // Reference oscillator or system clock over four
  assign tick = slot_clk_sel ? div_tick : ref_tick;
  // A module that overflowed waits for the next slot
  assign live = run & ~q.hold;
  assign slot_ovf = live & tick & (q.unit == `CTSC_UNIT_MAX)
                    & (q.slot == `CTSC_SLOT_MAX);
  assign cf_count = q.cf;

  // ==========================================================
  // Counter updates
  always_comb
  begin
    n = q;
    // Sense cycles of the selected key only
    if (live & key_tick[key_sel])
    begin
      n.cf = q.cf + 16'h1;
    end
    // Slot clock drives period, unit and slot counters
    if (live & tick)
    begin
      n.cnt  = q.cnt + 16'h1;
      n.unit = q.unit + 5'h1;
      if (q.unit == `CTSC_UNIT_MAX)
      begin
        n.slot = q.slot + 8'h1;
      end
    end
    // Overflow reloads the software period and halts
    if (slot_ovf)
    begin
      n.slot = preset;
      n.hold = 1'h1;
    end
    // End of a slot clears period and unit counters and reloads the slot counter
    if (slot_clr)
    begin
      n.cnt  = 16'h0;
      n.unit = 5'h0;
      n.slot = preset;
      n.hold = 1'h0;
    end
    if (cf_clr)
    begin
      n.cf = 16'h0;
    end
    // Start going low keeps the slot counter on purpose
    if (clr_all)
    begin
      n.cf   = 16'h0;
      n.cnt  = 16'h0;
      n.unit = 5'h0;
      n.hold = 1'h0;
    end
  end

  // Register stage
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      q <= '0;
    else
      q <= n;
  end

endmodule
`default_nettype wire

//--- logic/ctsc_top.sv
// Capacitive touch scan controller: registers, sequencer and data memory
`timescale 1ns/100ps
`default_nettype none
`include "ctsc_map.svh"

// Behaviour
// - Count sense cycles within divided reference window
// - Four independent sense oscillators per identical module
// - Shared start; module 0 slot counter optionally shared
// - Start low clears frequency, period, unit counters
// - Start low leaves slot counter unchanged
// - Start rising edge switches all counters on
// - Slot overflow stops counters; oscillators stop when busy falls
// - Slot clock: reference oscillator or clock/4
// - Oscillators run when their enable bits set
// - Interrupt on overflow of enabled modules; clear
// - Manual mode interrupts at window end
// - Mode bit low auto, high manual
// - Auto scans keys in slot select order
// - Auto enables key oscillators at start, reference ones on reference slot clock; off at busy
// - Auto start loads first capacitor value
// - Then write count to last result location
// - Slot end: load next capacitor, store count
// - Four slots, then overflow high, busy low
// - Completion reloads first capacitor, stores count
// - Separate result and capacitor memories
// - Overflow flag set together with interrupt
// - Select codes map keys; slot 0 manual mux
// - Auto clears count after slots 0-2 only
module ctsc_top
(
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  // AXI4-Lite write address and data
  input  wire logic [11:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Analog oscillator side
  input  wire logic [`CTSC_NMOD-1:0]   ref_tick,
  input  wire logic [`CTSC_NMOD*4-1:0] key_tick,
  output logic [`CTSC_NMOD-1:0]        ref_osc_enable,
  output logic [`CTSC_NMOD*4-1:0]      key_osc_enable,
  output logic [`CTSC_NMOD*2-1:0]      key_mux_sel,
  output logic [`CTSC_NMOD*10-1:0]     ref_cap_value,
  // Touch interrupt
  output logic                         touch_irq
);

  localparam int NM = `CTSC_NMOD;
  localparam int NK = `CTSC_NKEY;

  // ==========================================================
  // State and local signals
  ctsc_pkg::ctsc_top_state_t q;       // Registered state
  ctsc_pkg::ctsc_top_state_t n;       // Next state
  logic [NM-1:0][15:0]       cf_all;  // Frequency counts
  logic [NM-1:0]             ovf_p;   // Per-module slot overflow
  logic [NM-1:0]             used;    // Modules with keys enabled
  logic [NM-1:0][1:0]        sel;     // Key being counted
  logic                      rise;    // Start low to high
  logic                      fall;    // Start high to low
  logic                      slot_end;
  logic                      cf_clr;
  logic                      div_tick;
  logic                      wr_go;

  // Start edges as single-cycle pulses
  assign rise = q.start & ~q.start_d1;
  assign fall = ~q.start & q.start_d1;
  assign div_tick = (q.div == `CTSC_DIV_MAX);
  assign wr_go = q.aw_v & q.w_v & ~q.bvalid;
  // Module 0 alone, or every module in use, ends a slot
  assign slot_end = (q.phase == ctsc_pkg::ph_scan)
                    & (q.shared ? ovf_p[0] : &(q.done | ovf_p | ~used));
  // Count is kept at the end of the last auto slot
  assign cf_clr = fall
                  | (slot_end & ~q.mode & (q.slot != `CTSC_LAST_SLOT));
  assign touch_irq = q.irq;

  // ==========================================================
  // Per-module counters and pins; all modules alike
  for (genvar m = 0; m < NM; m++)
  begin : g_mod
    // Manual mode muxes with the slot 0 field
    assign sel[m] = q.mode ? q.mc2[m][1:0]
                           : q.mc2[m][{q.slot, 1'h0} +: 2];
    assign used[m] = |q.mc1[m][`CTSC_F_KEN];
    assign key_mux_sel[m*2 +: 2] = sel[m];
    assign ref_cap_value[m*10 +: 10] = q.refcap[m];
    // Oscillators follow their enable bits
    assign ref_osc_enable[m] = q.mc1[m][`CTSC_B_ROEN];
    assign key_osc_enable[m*4 +: 4] = q.mc1[m][`CTSC_F_KEN]
                                      & {4{q.mc1[m][`CTSC_B_KOEN]}};
    ctsc_chan u_chan
    (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .run          (q.run),
      .clr_all      (fall),
      .slot_clr     (rise | slot_end),
      .cf_clr       (cf_clr),
      .slot_clk_sel (q.mc1[m][`CTSC_B_TSS]),
      .div_tick     (div_tick),
      .preset       (q.preset),
      .key_sel      (sel[m]),
      .ref_tick     (ref_tick[m]),
      .key_tick     (key_tick[m*4 +: 4]),
      .cf_count     (cf_all[m]),
      .slot_ovf     (ovf_p[m])
    );
  end

  // ==========================================================
  // Register read decode; bit 32 marks a mapped address
  function automatic logic [32:0] rd_word
  (
    input ctsc_pkg::ctsc_top_state_t s,
    input logic [11:0]               a,
    input logic [NM-1:0][15:0]       cf
  );
    logic [32:0] r;
    logic [1:0]  m;
    r = '0;
    m = a[5:4];
    if (a == `CTSC_OFF_CTRL0)
    begin
      r[`CTSC_B_HIT]   = 1'h1;
      r[`CTSC_B_START] = s.start;
      r[`CTSC_B_MODE]  = s.mode;
      r[`CTSC_B_BUSY]  = s.busy;
      r[`CTSC_B_OVF]   = s.ovf;
    end
    else if (a == `CTSC_OFF_CTRL1)
    begin
      r[`CTSC_B_HIT]    = 1'h1;
      r[`CTSC_B_SHARED] = s.shared;
      r[`CTSC_F_PRESET] = s.preset;
    end
    else if ((a[11:6] == `CTSC_PG_MOD) && (m < NM))
    begin
      r[`CTSC_B_HIT] = 1'h1;
      unique case (a[3:2])
        `CTSC_SUB_MC1: r[7:0]  = s.mc1[m];
        `CTSC_SUB_MC2: r[7:0]  = s.mc2[m];
        `CTSC_SUB_CAP: r[9:0]  = s.refcap[m];
        default:       r[15:0] = cf[m];
      endcase
    end
    // Capacitor memory and result memory live apart
    else if (a[11:5] == `CTSC_PG_CAP)
    begin
      r[`CTSC_B_HIT] = 1'h1;
      r[9:0]         = s.capmem[a[4:2]];
    end
    else if (a[11:5] == `CTSC_PG_RES)
    begin
      r[`CTSC_B_HIT] = 1'h1;
      r[15:0]        = s.resmem[a[4:2]];
    end
    return r;
  endfunction

  // Byte-lane merge of a write into the old word
  function automatic logic [31:0] merge
  (
    input logic [31:0] o,
    input logic [31:0] d,
    input logic [3:0]  s
  );
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[b*8 +: 8] = d[b*8 +: 8];
    return r;
  endfunction

  assign s_axi_awready = ~q.aw_v & ~q.bvalid;
  assign s_axi_wready  = ~q.w_v & ~q.bvalid;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  // ==========================================================
  // Next-state logic: bus first, so hardware events win over writes
  always_comb
  begin
    logic [32:0] rw;
    logic [32:0] rr;
    logic [31:0] wv;
    logic [1:0]  m;
    rw = rd_word(q, q.awaddr, cf_all);
    rr = rd_word(q, s_axi_araddr, cf_all);
    wv = merge(rw[31:0], q.wdata, q.wstrb);
    m  = q.awaddr[5:4];
    n  = q;
    n.irq      = 1'h0;
    n.start_d1 = q.start;
    n.div      = q.div + 2'h1;
    // Address and data are taken in either order
    if (s_axi_awvalid & s_axi_awready)
    begin
      n.aw_v   = 1'h1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready)
    begin
      n.w_v   = 1'h1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid & s_axi_bready)
      n.bvalid = 1'h0;
    if (wr_go)
    begin
      n.aw_v   = 1'h0;
      n.w_v    = 1'h0;
      n.bvalid = 1'h1;
      n.bresp  = rw[`CTSC_B_HIT] ? `CTSC_RESP_OK : `CTSC_RESP_ERR;
      if (q.awaddr == `CTSC_OFF_CTRL0)
      begin
        n.start = wv[`CTSC_B_START];
        n.mode  = wv[`CTSC_B_MODE];
        // Writing zero clears the overflow flag
        if (!wv[`CTSC_B_OVF])
          n.ovf = 1'h0;
      end
      else if (q.awaddr == `CTSC_OFF_CTRL1)
      begin
        n.shared = wv[`CTSC_B_SHARED];
        n.preset = wv[`CTSC_F_PRESET];
      end
      else if ((q.awaddr[11:6] == `CTSC_PG_MOD) && (m < NM))
      begin
        unique case (q.awaddr[3:2])
          `CTSC_SUB_MC1: n.mc1[m] = wv[7:0] & `CTSC_MC1_MASK;
          `CTSC_SUB_MC2: n.mc2[m] = wv[7:0];
          `CTSC_SUB_CAP: n.refcap[m] = wv[9:0];
          default:       ;
        endcase
      end
      else if (q.awaddr[11:5] == `CTSC_PG_CAP)
        n.capmem[q.awaddr[4:2]] = wv[9:0];
    end
    // Reads answer one cycle after the address is taken
    if (s_axi_rvalid & s_axi_rready)
      n.rvalid = 1'h0;
    if (s_axi_arvalid & s_axi_arready)
    begin
      n.rvalid = 1'h1;
      n.rdata  = rr[31:0];
      n.rresp  = rr[`CTSC_B_HIT] ? `CTSC_RESP_OK : `CTSC_RESP_ERR;
    end

    // Sequencer
    n.done = q.done | ovf_p;
    if (rise)
    begin
      // Manual mode switches the counters on with the start edge, auto mode after the load phase
      n.busy = 1'h1;
      n.slot = 2'h0;
      n.done = '0;
      if (q.mode)
      begin
        n.run   = 1'h1;
        n.phase = ctsc_pkg::ph_scan;
      end
      else
      begin
        n.phase = ctsc_pkg::ph_load;
        // Auto mode turns the key oscillators on itself, and the reference one if it clocks the slot
        for (int i = 0; i < NM; i++)
        begin
          n.mc1[i][`CTSC_B_KOEN] = 1'h1;
          if (!q.mc1[i][`CTSC_B_TSS])
            n.mc1[i][`CTSC_B_ROEN] = 1'h1;
        end
      end
    end
    else if (fall)
    begin
      n.run   = 1'h0;
      n.busy  = 1'h0;
      n.phase = ctsc_pkg::ph_idle;
    end
    else if (q.phase == ctsc_pkg::ph_load)
    begin
      // First capacitor in, then count to last location
      for (int i = 0; i < NM; i++)
      begin
        n.refcap[i] = q.capmem[i*NK];
        n.resmem[i*NK + NK - 1] = cf_all[i];
      end
      n.run   = 1'h1;
      n.phase = ctsc_pkg::ph_scan;
    end
    else if (slot_end)
    begin
      n.done = '0;
      if (q.mode || (q.slot == `CTSC_LAST_SLOT))
      begin
        // Window done: flag, interrupt and stop
        n.ovf   = 1'h1;
        n.irq   = 1'h1;
        n.busy  = 1'h0;
        n.run   = 1'h0;
        n.phase = ctsc_pkg::ph_idle;
        if (!q.mode)
        begin
          // Completion reloads first capacitor and stores count
          for (int i = 0; i < NM; i++)
          begin
            n.refcap[i] = q.capmem[i*NK];
            n.resmem[i*NK + NK - 1] = cf_all[i];
          end
        end
      end
      else
      begin
        // Next capacitor loaded and current count stored in the same cycle
        for (int i = 0; i < NM; i++)
        begin
          n.refcap[i] = q.capmem[i*NK + int'(q.slot) + 1];
          n.resmem[i*NK + int'(q.slot)] = cf_all[i];
        end
        n.slot = q.slot + 2'h1;
      end
    end
    // Busy falling switches both oscillators off
    if (q.busy && !n.busy)
    begin
      for (int i = 0; i < NM; i++)
      begin
        n.mc1[i][`CTSC_B_ROEN] = 1'h0;
        n.mc1[i][`CTSC_B_KOEN] = 1'h0;
      end
    end
  end

  // Register stage
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      q        <= '0;
      q.preset <= `CTSC_PRE_RST;
      q.mc2    <= {NM{`CTSC_MC2_RST}};
    end
    else
      q <= n;
  end

  // ==========================================================
  // Assertions
  a_irq_with_flag: assert property (@(posedge sys_clk) disable iff (reset)
    touch_irq |-> q.ovf && !q.busy)
    else $error("interrupt without overflow flag");
  a_stop_clears_cf: assert property (@(posedge sys_clk) disable iff (reset)
    fall |=> cf_all == '0)
    else $error("count not cleared when start fell");
  a_rise_busy: assert property (@(posedge sys_clk) disable iff (reset)
    rise |=> q.busy && q.phase != ctsc_pkg::ph_idle)
    else $error("start edge did not begin a scan");
  a_busy_fall_osc: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(q.busy) |-> ref_osc_enable == '0 && key_osc_enable == '0)
    else $error("oscillators left on after busy fell");
  a_load_cap: assert property (@(posedge sys_clk) disable iff (reset)
    q.phase == ctsc_pkg::ph_load && !fall
    |=> q.refcap[0] == $past(q.capmem[0]) && q.run)
    else $error("first capacitor value not loaded");
  a_manual_key: assert property (@(posedge sys_clk) disable iff (reset)
    q.mode |-> key_mux_sel[1:0] == q.mc2[0][1:0])
    else $error("manual key select not from slot 0 field");
  a_ovf_last_slot: assert property (@(posedge sys_clk) disable iff (reset)
    touch_irq && !q.mode |-> q.slot == `CTSC_LAST_SLOT)
    else $error("auto scan ended before slot 3");
  a_div_period: assert property (@(posedge sys_clk) disable iff (reset)
    div_tick |=> !div_tick [*3] ##1 div_tick)
    else $error("system clock divider is not four");
  a_shared_end: assert property (@(posedge sys_clk) disable iff (reset)
    q.phase == ctsc_pkg::ph_scan && q.shared && ovf_p[0] && !fall
    |=> q.slot != $past(q.slot) || !q.busy)
    else $error("module 0 overflow did not end the slot");

endmodule
`default_nettype wire

//--- dv/ctsc_pad_model.sv
// Behavioural touch pads: reference and sense oscillators as clock ticks
`timescale 1ns/100ps
`default_nettype none

module ctsc_pad_model
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Oscillator enables from the controller
  input  wire logic [1:0] ref_osc_enable,
  input  wire logic [7:0] key_osc_enable,
  // Oscillator ticks to the controller
  output logic      [1:0] ref_tick,
  output logic      [7:0] key_tick
);
  // ==========================================================
  // Oscillators
  logic [15:0] phase_q;   // Free-running phase shared by all pads

  // Each key has its own rate, so a wrong key select shows as a wrong count
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      phase_q  <= 16'h0000;
      ref_tick <= 2'h0;
      key_tick <= 8'h00;
    end
    else
    begin
      phase_q <= phase_q + 16'h0001;
      for (int m = 0; m < 2; m++)
      begin
        // A stopped oscillator gives no ticks at all
        ref_tick[m] <= ref_osc_enable[m] && (phase_q % 16'd3 == 16'd0);
        for (int k = 0; k < 4; k++)
          key_tick[m*4+k] <= key_osc_enable[m*4+k] &&
                             (phase_q % 16'(k + 3) == 16'd0);
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/ctsc_tb_top.sv
// Self-checking bench of the capacitive touch scan controller
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module ctsc_tb_top;
  // ==========================================================
  // Signals
  logic        sys_clk, reset;                  // Clock and reset
  logic [11:0] s_axi_awaddr, s_axi_araddr;      // Bus addresses
  logic [31:0] s_axi_wdata, s_axi_rdata;        // Bus data
  logic [3:0]  s_axi_wstrb;                     // Byte lanes
  logic [1:0]  s_axi_bresp, s_axi_rresp;        // Response codes
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, touch_irq;
  logic [1:0]  ref_tick, ref_osc_enable;        // Per module
  logic [7:0]  key_tick, key_osc_enable;        // Per key
  logic [3:0]  key_mux_sel;                     // Counted key
  logic [19:0] ref_cap_value;                   // Capacitor settings
  logic [31:0] rd_data;                         // Last word read
  logic [1:0]  rd_resp;                         // Last read response
  logic [1:0]  wr_resp;                         // Last write response
  int          err_count = 0;                   // Mismatches
  int          checked = 0;                     // Comparisons
  int          cycles = 0;                      // Run length

  // ==========================================================
  // Design and pads
  ctsc_top ctsc_top_i
  (
    .sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ref_tick, .key_tick, .ref_osc_enable,
    .key_osc_enable, .key_mux_sel, .ref_cap_value, .touch_irq
  );

  ctsc_pad_model ctsc_pad_model_i
  (
    .sys_clk, .reset, .ref_osc_enable, .key_osc_enable, .ref_tick,
    .key_tick
  );

  // ==========================================================
  // Clock, timeout and verdict
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // A hung handshake ends the run here; wait_irq gives up on its own after 3000 cycles
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Bus tasks: handshakes are judged at the falling edge, where the
  // values that the next rising edge will see are already settled
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_go, w_go, b_go;
    b_go = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_go)
    begin
      @(negedge sys_clk);
      aw_go = s_axi_awvalid & s_axi_awready;
      w_go  = s_axi_wvalid & s_axi_wready;
      b_go  = s_axi_bvalid & s_axi_bready;
      wr_resp = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_go)
        s_axi_awvalid <= 1'b0;
      if (w_go)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    logic ar_go, r_go;
    r_go = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r_go)
    begin
      @(negedge sys_clk);
      ar_go   = s_axi_arvalid & s_axi_arready;
      r_go    = s_axi_rvalid & s_axi_rready;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge sys_clk);
      if (ar_go)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_data, e)
  endtask

  // Interrupt is a one-cycle pulse, so it is looked at every cycle
  task automatic wait_irq();
    int n;
    n = 0;
    while (touch_irq !== 1'b1 && n < 3000)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(touch_irq, 1'b1)
    @(posedge sys_clk);
  endtask

  // ==========================================================
  // Test sequence
  initial
  begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(12'h044, 32'h0000_00e4);
    rd(12'h3f0);
    `CHK({rd_resp, rd_data}, {2'h2, 32'h0})
    wr(12'h3f0, 32'h0000_0001);
    `CHK(wr_resp, 2'h2)
    // Manual scan of key 2 in module 0, short window on clock/4
    wr(12'h004, 32'h0000_fe00);
    `CHK(wr_resp, 2'h0)
    wr(12'h044, 32'h0000_00e6);
    wr(12'h040, 32'h0000_00b4);
    rchk(12'h040, 32'h0000_00b4);
    `CHK(key_mux_sel[1:0], 2'h2)
    `CHK(key_osc_enable[3:0], 4'h4)
    wr(12'h000, 32'h0000_0003);
    wait_irq();
    rchk(12'h000, 32'h0000_000b);
    `CHK({ref_osc_enable, key_osc_enable}, 10'h000)
    rd(12'h04c);
    `CHK(rd_data[15:0] > 16'd40 && rd_data[15:0] < 16'd60, 1'b1)
    // Dropping start clears the count and the flag
    wr(12'h000, 32'h0000_0000);
    rchk(12'h04c, 32'h0000_0000);
    rchk(12'h000, 32'h0000_0000);
    // Auto scan with only key 1 oscillating, met in slot 1 alone
    wr(12'h044, 32'h0000_00e4);
    for (int i = 0; i < 4; i++)
      wr(12'h100 + 12'(i * 4), 32'h2a0 + 32'(i));
    rchk(12'h108, 32'h0000_02a2);
    wr(12'h040, 32'h0000_0082);
    wr(12'h000, 32'h0000_0001);
    rchk(12'h000, 32'h0000_0005);
    `CHK(key_osc_enable[3:0], 4'h2)
    `CHK(ref_cap_value[9:0], 10'h2a0)
    wait_irq();
    rchk(12'h000, 32'h0000_0009);
    `CHK(ref_cap_value[9:0], 10'h2a0)
    `CHK(key_osc_enable, 8'h00)
    rchk(12'h200, 32'h0000_0000);
    rd(12'h204);
    `CHK(rd_data[15:0] > 16'd50 && rd_data[15:0] < 16'd80, 1'b1)
    rchk(12'h208, 32'h0000_0000);
    rchk(12'h20c, 32'h0000_0000);
    // Shared slot counter: module 0 on its reference oscillator ends
    // every slot, so module 1 on clock/4 never reaches its own overflow
    wr(12'h000, 32'h0000_0000);
    wr(12'h004, 32'h0000_fe01);
    wr(12'h040, 32'h0000_0001);
    wr(12'h050, 32'h0000_0081);
    wr(12'h000, 32'h0000_0001);
    rchk(12'h040, 32'h0000_0031);
    `CHK(ref_osc_enable, 2'h1)
    wait_irq();
    rd(12'h200);
    `CHK(rd_data[15:0] > 16'd55 && rd_data[15:0] < 16'd75, 1'b1)
    rd(12'h210);
    `CHK(rd_data[15:0] > 16'd55 && rd_data[15:0] < 16'd75, 1'b1)
    `CHK(ref_osc_enable, 2'h0)
    conclude();
  end
endmodule
`default_nettype wire
